// [verilog/eps_regs.svh]
// Constants for the EPROM programmer scan control block
`ifndef EPS_REGS_SVH
`define EPS_REGS_SVH

// Widths of the address counter, data word and FIFO entry, and the FIFO depth
`define EPS_ADDR_W        13
`define EPS_LOW_W         12
`define EPS_DATA_W        8
`define EPS_FIFO_W        22
`define EPS_FIFO_DEPTH    32

// Keypad register field positions
`define EPS_KEY_TOP_BIT   4

// Reset values
`define EPS_ADDR_RST      13'h0000
`define EPS_DATA_RST      8'h00

// Timing in its own units
`define EPS_CLK_MHZ       100
`define EPS_PULSE_SHORT_US 1000
`define EPS_PULSE_LONG_US 2000
`define EPS_ACCESS_NS     40
`define EPS_REPEAT_NS     1000

`endif

// [verilog/eps_pkg.sv]
// Types for the EPROM programmer scan control block
package eps_pkg;

    // Position of the mode switch
    typedef enum logic [1:0] {
        EPS_MODE_KEYPAD  = 2'h0,
        EPS_MODE_BURN    = 2'h1,
        EPS_MODE_LOADVER = 2'h2,
        EPS_MODE_EMULATE = 2'h3
    } eps_mode_type;

    // Position of the pulse selector
    typedef enum logic [1:0] {
        EPS_PSEL_SHORT  = 2'h0,
        EPS_PSEL_LONG   = 2'h1,
        EPS_PSEL_SERIAL = 2'h2
    } eps_psel_type;

    // Scan sequencer states, one-hot
    typedef enum logic [3:0] {
        EPS_ST_IDLE = 4'h1,
        EPS_ST_ADDR = 4'h2,
        EPS_ST_ACT  = 4'h4,
        EPS_ST_STEP = 4'h8
    } eps_state_type;

endpackage

// [verilog/eps_fifo.sv]
// Small synchronous FIFO with valid and ready on both sides
`timescale 1ns/1ps
`default_nettype none

module eps_fifo #(
    parameter int WIDTH = 22,
    parameter int DEPTH = 32
) (
    input  wire logic             clk_sys_i,  // System clock
    input  wire logic             rst_i,      // Async reset, high
    input  wire logic             in_valid_i, // Entry offered
    output logic                  in_ready_o, // Room for an entry
    input  wire logic [WIDTH-1:0] in_data_i,  // Entry written
    output logic                  out_valid_o, // Entry available
    input  wire logic             out_ready_i, // Entry taken
    output logic [WIDTH-1:0]      out_data_o  // Oldest entry
);

    localparam int PW = $clog2(DEPTH);

    logic [WIDTH-1:0] mem_reg [DEPTH];
    logic [PW-1:0]    wr_ptr_reg;
    logic [PW-1:0]    rd_ptr_reg;
    logic [PW:0]      count_reg;
    logic [PW:0]      count_next;
    logic             push;
    logic             pop;
    logic             ready_reg;

    // ************************************************************
    // Handshake decode
    // ************************************************************
    assign push        = in_valid_i & ready_reg;
    assign pop         = out_valid_o & out_ready_i;
    assign out_valid_o = (count_reg != '0);
    assign out_data_o  = mem_reg[rd_ptr_reg];
    assign in_ready_o  = ready_reg;
    assign count_next  = count_reg + (PW+1)'(push) - (PW+1)'(pop);

    // Pointers, fill count and registered ready
    always_ff @(posedge clk_sys_i or posedge rst_i) begin
        if (rst_i) begin
            wr_ptr_reg <= '0;
            rd_ptr_reg <= '0;
            count_reg  <= '0;
            ready_reg  <= 1'b0;
        end else begin
            wr_ptr_reg <= wr_ptr_reg + PW'(push);
            rd_ptr_reg <= rd_ptr_reg + PW'(pop);
            count_reg  <= count_next;
            ready_reg  <= (count_next < (PW+1)'(DEPTH));
        end
    end

    // Storage array, no reset
    always_ff @(posedge clk_sys_i) begin
        if (push) begin
            mem_reg[wr_ptr_reg] <= in_data_i;
        end
    end

endmodule

`default_nettype wire

// [verilog/eps_scan_ctrl.sv]
// Keypad, RAM buffer and scan sequencer of the EPROM programmer
`timescale 1ns/1ps
`default_nettype none
`include "eps_regs.svh"

module eps_scan_ctrl #(
    parameter int PULSE_SHORT_CYC = `EPS_PULSE_SHORT_US * `EPS_CLK_MHZ,
    parameter int PULSE_LONG_CYC  = `EPS_PULSE_LONG_US * `EPS_CLK_MHZ
) (
    input  wire logic                 clk_sys_i,      // System clock
    input  wire logic                 rst_i,          // Async reset, high
    input  wire eps_pkg::eps_mode_type mode_i,        // Mode switch
    input  wire eps_pkg::eps_psel_type psel_i,        // Pulse selector
    input  wire logic                 write_permit_i, // RAM write permit
    input  wire logic                 repeat_i,       // Auto-repeat held
    input  wire logic                 stop_i,         // Stop button
    input  wire logic                 show_device_word_button_i, // Show dev
    input  wire logic                 digit_stb_i,    // Hex digit pulse
    input  wire logic [3:0]           digit_i,        // Hex digit value
    input  wire logic                 upper_set_i,    // Upper pair key
    input  wire logic                 lower_set_i,    // Lower pair key
    input  wire logic                 write_step_i,   // Write-step key
    input  wire logic [7:0]           dev_data_i,     // Socket data in
    input  wire logic [12:0]          ext_addr_i,     // Outside address
    input  wire logic                 ext_sel_n_i,    // Outside select
    input  wire logic                 ser_valid_i,    // Serial entry
    input  wire logic                 ser_write_i,    // Entry is a write
    input  wire logic [12:0]          ser_addr_i,     // Serial address
    input  wire logic [7:0]           ser_data_i,     // Serial data
    output logic                      ser_ready_o,    // Serial room
    output logic                      ser_rd_valid_o, // Read answer pulse
    output logic [7:0]                ser_rd_data_o,  // Read answer data
    output logic [12:0]               dev_addr_o,     // Socket address
    output logic                      dev_sel_n_o,    // Socket select
    output logic [7:0]                dev_data_o,     // Socket data out
    output logic                      dev_data_oe_o,  // Socket data drive
    output logic                      dev_prog_pulse_o, // Program pulse
    output logic [12:0]               addr_disp_o,    // Address readout
    output logic [7:0]                data_disp_o,    // Data readout
    output logic                      scan_run_o,     // Scan running
    output logic                      mismatch_o      // Stopped on error
);

    localparam int ACC_CYC =
        (`EPS_ACCESS_NS * `EPS_CLK_MHZ + 999) / 1000;
    localparam int REP_CYC = (`EPS_REPEAT_NS * `EPS_CLK_MHZ) / 1000;

    // Advance inside the selected half only
    function automatic logic [12:0] eps_inc(input logic [12:0] a);
        eps_inc = {a[12], a[11:0] + 12'h001};
    endfunction

    eps_pkg::eps_state_type state_reg;
    eps_pkg::eps_state_type state_next;
    logic [7:0]   key_reg;
    logic [12:0]  addr_reg;
    logic [12:0]  addr_next;
    logic [17:0]  wait_reg;
    logic         load_reg;
    eps_pkg::eps_mode_type scan_mode_reg;
    logic         rep_run_reg;
    logic [7:0]   rep_div_reg;
    logic [7:0]   ram_reg [8192];
    logic [7:0]   ram_q_reg;
    logic         ser_pend_reg;
    logic [17:0]  pulse_last;
    logic         acc_done;
    logic         pulse_done;
    logic         m_key;
    logic         m_burn;
    logic         m_lv;
    logic         m_emu;
    logic         rep_tick;
    logic         kp_step;
    logic         kp_write;
    logic         start;
    logic         halt;
    logic         differ;
    logic         scan_write;
    logic         ser_en;
    logic         ser_go;
    logic         fifo_valid;
    logic [21:0]  fifo_data;
    logic         ram_we;
    logic [12:0]  ram_addr;
    logic [7:0]   ram_wdata;
    logic         idle;
    logic         in_addr;
    logic         in_act;
    logic         in_step;

    // ************************************************************
    // Mode and key decode
    // ************************************************************
    assign m_key    = (mode_i == eps_pkg::EPS_MODE_KEYPAD);
    assign m_burn   = (mode_i == eps_pkg::EPS_MODE_BURN);
    assign m_lv     = (mode_i == eps_pkg::EPS_MODE_LOADVER);
    assign m_emu    = (mode_i == eps_pkg::EPS_MODE_EMULATE);
    assign idle     = (state_reg == eps_pkg::EPS_ST_IDLE);
    assign in_addr  = (state_reg == eps_pkg::EPS_ST_ADDR);
    assign in_act   = (state_reg == eps_pkg::EPS_ST_ACT);
    assign in_step  = (state_reg == eps_pkg::EPS_ST_STEP);
    assign rep_tick = rep_run_reg & (rep_div_reg == 8'(REP_CYC - 1));
    assign kp_step  = m_key & (write_step_i | rep_tick);
    assign kp_write = kp_step & write_permit_i;
    assign start    = write_step_i & idle & (m_burn | m_lv);

    // ************************************************************
    // Sequencer decode
    // ************************************************************
    assign pulse_last = (psel_i == eps_pkg::EPS_PSEL_LONG) ?
        18'(PULSE_LONG_CYC - 1) : 18'(PULSE_SHORT_CYC - 1);
    assign acc_done   = (wait_reg == 18'(ACC_CYC - 1));
    assign pulse_done = (wait_reg == pulse_last);
    assign halt       = stop_i | (mode_i != scan_mode_reg);
    assign differ     = in_act & m_lv & ~load_reg &
        (dev_data_i != ram_q_reg);
    assign scan_write = in_act & load_reg & ~halt;

    // Next state of the scan sequencer
    always_comb begin
        state_next = state_reg;
        case (state_reg)
            eps_pkg::EPS_ST_IDLE: begin
                if (start) begin
                    state_next = eps_pkg::EPS_ST_ADDR;
                end
            end
            eps_pkg::EPS_ST_ADDR: begin
                if (halt) begin
                    state_next = eps_pkg::EPS_ST_IDLE;
                end else if (acc_done) begin
                    state_next = eps_pkg::EPS_ST_ACT;
                end
            end
            eps_pkg::EPS_ST_ACT: begin
                if (halt || differ) begin
                    state_next = eps_pkg::EPS_ST_IDLE;
                end else if (!m_burn || pulse_done) begin
                    state_next = eps_pkg::EPS_ST_STEP;
                end
            end
            eps_pkg::EPS_ST_STEP: begin
                state_next = halt ? eps_pkg::EPS_ST_IDLE :
                    eps_pkg::EPS_ST_ADDR;
            end
            default: begin
                state_next = eps_pkg::EPS_ST_IDLE;
            end
        endcase
    end

    // ************************************************************
    // Address counter
    // ************************************************************
    assign addr_next =
        upper_set_i && idle ? {key_reg[`EPS_KEY_TOP_BIT], key_reg[3:0],
                       addr_reg[7:0]} :
        lower_set_i && idle ? {addr_reg[12:8], key_reg} :
        (kp_step || in_step) ? eps_inc(addr_reg) :
        addr_reg;

    // Keypad register shifts digits in, most significant first
    always_ff @(posedge clk_sys_i or posedge rst_i) begin
        if (rst_i) begin
            key_reg <= `EPS_DATA_RST;
        end else if (digit_stb_i) begin
            key_reg <= {key_reg[3:0], digit_i};
        end
    end

    // Address loads from the keys while idle and advances in the step state
    always_ff @(posedge clk_sys_i or posedge rst_i) begin
        if (rst_i) begin
            addr_reg <= `EPS_ADDR_RST;
        end else if (idle || in_step) begin
            addr_reg <= addr_next;
        end
    end

    // Repeat run and its step divider
    always_ff @(posedge clk_sys_i or posedge rst_i) begin
        if (rst_i) begin
            rep_run_reg <= 1'b0;
            rep_div_reg <= 8'h00;
        end else begin
            rep_run_reg <= repeat_i & m_key &
                (rep_run_reg | write_step_i);
            rep_div_reg <= (rep_tick || !rep_run_reg) ? 8'h00 :
                rep_div_reg + 8'h01;
        end
    end

    // Sequencer state, wait counter and scan kind
    always_ff @(posedge clk_sys_i or posedge rst_i) begin
        if (rst_i) begin
            state_reg     <= eps_pkg::EPS_ST_IDLE;
            wait_reg      <= 18'h00000;
            load_reg      <= 1'b0;
            scan_mode_reg <= eps_pkg::EPS_MODE_KEYPAD;
        end else begin
            state_reg <= state_next;
            wait_reg  <= (state_next != state_reg) ? 18'h00000 :
                wait_reg + 18'h00001;
            if (start) begin
                load_reg      <= write_permit_i;
                scan_mode_reg <= mode_i;
            end
        end
    end

    // ************************************************************
    // RAM port, serial FIFO drain and emulation path
    // ************************************************************
    assign ser_en    = m_key & (psel_i == eps_pkg::EPS_PSEL_SERIAL);
    assign ser_go    = ser_en & fifo_valid & ~kp_step;
    assign ram_addr  = m_emu ? ext_addr_i :
        ser_go ? fifo_data[20:8] : addr_reg;
    assign ram_wdata = kp_write ? key_reg :
        scan_write ? dev_data_i : fifo_data[7:0];
    assign ram_we    = ~m_emu &
        (kp_write | scan_write | (ser_go & fifo_data[21]));

    // Serial host entries wait here while RAM is not granted
    eps_fifo #(
        .WIDTH (`EPS_FIFO_W),
        .DEPTH (`EPS_FIFO_DEPTH)
    ) u_fifo (
        .clk_sys_i   (clk_sys_i),
        .rst_i       (rst_i),
        .in_valid_i  (ser_valid_i),
        .in_ready_o  (ser_ready_o),
        .in_data_i   ({ser_write_i, ser_addr_i, ser_data_i}),
        .out_valid_o (fifo_valid),
        .out_ready_i (ser_go),
        .out_data_o  (fifo_data)
    );

    // Buffer RAM with registered read
    always_ff @(posedge clk_sys_i) begin
        if (ram_we) begin
            ram_reg[ram_addr] <= ram_wdata;
        end
        ram_q_reg <= ram_reg[ram_addr];
    end

    // ************************************************************
    // Outputs
    // ************************************************************
    always_ff @(posedge clk_sys_i or posedge rst_i) begin
        if (rst_i) begin
            ser_pend_reg     <= 1'b0;
            ser_rd_valid_o   <= 1'b0;
            ser_rd_data_o    <= `EPS_DATA_RST;
            dev_addr_o       <= `EPS_ADDR_RST;
            dev_sel_n_o      <= 1'b1;
            dev_data_o       <= `EPS_DATA_RST;
            dev_data_oe_o    <= 1'b0;
            dev_prog_pulse_o <= 1'b0;
            addr_disp_o      <= `EPS_ADDR_RST;
            data_disp_o      <= `EPS_DATA_RST;
            scan_run_o       <= 1'b0;
            mismatch_o       <= 1'b0;
        end else begin
            ser_pend_reg   <= ser_go & ~fifo_data[21];
            ser_rd_valid_o <= ser_pend_reg;
            if (ser_pend_reg) begin
                ser_rd_data_o <= ram_q_reg;
            end
            dev_addr_o    <= addr_reg;
            dev_sel_n_o   <= ~(((in_addr | in_act) & ~m_burn & ~state_next[0])
                | (show_device_word_button_i & idle & ~m_emu));
            dev_data_o    <= ram_q_reg;
            dev_data_oe_o <= (m_emu & ~ext_sel_n_i) |
                (m_burn & (in_addr | in_act) & ~state_next[0]);
            dev_prog_pulse_o <= m_burn &
                (state_next == eps_pkg::EPS_ST_ACT);
            addr_disp_o   <= addr_reg;
            data_disp_o   <= show_device_word_button_i ? dev_data_i :
                ram_q_reg;
            scan_run_o    <= ~state_next[0];
            mismatch_o    <= differ | (mismatch_o & ~start);
        end
    end

endmodule

`default_nettype wire

// [verification/eps_scan_ctrl_chk.sv]
// Assertion checker for the scan control block
`timescale 1ns/1ps
`default_nettype none

module eps_scan_ctrl_chk #(
    parameter int PULSE_SHORT_CYC = 100000,
    parameter int PULSE_LONG_CYC  = 200000
) (
    input wire logic                  clk_sys_i,        // Clock
    input wire logic                  rst_i,            // Reset
    input wire eps_pkg::eps_mode_type mode_i,           // Mode
    input wire eps_pkg::eps_psel_type psel_i,           // Pulse select
    input wire logic                  stop_i,           // Stop
    input wire logic                  digit_stb_i,      // Digit pulse
    input wire logic [3:0]            digit_i,          // Digit
    input wire logic                  upper_set_i,      // Upper key
    input wire logic                  lower_set_i,      // Lower key
    input wire logic                  write_step_i,     // Step key
    input wire logic                  ext_sel_n_i,      // Outside select
    input wire logic                  dev_prog_pulse_o, // Pulse
    input wire logic                  dev_data_oe_o,    // Drive
    input wire logic [12:0]           addr_disp_o,      // Address
    input wire logic                  scan_run_o,       // Running
    input wire logic                  mismatch_o        // Mismatch
);
    // ****
    // Helper logic
    // ****
    logic [7:0]  key_reg;
    logic [31:0] plen_reg;
    logic [4:0]  ktop;
    logic        kp_idle;
    logic        scan_mode;

    // Mode decode
    assign ktop      = key_reg[4:0];
    assign kp_idle   = (mode_i == eps_pkg::EPS_MODE_KEYPAD) && !scan_run_o;
    assign scan_mode = (mode_i == eps_pkg::EPS_MODE_BURN) ||
                       (mode_i == eps_pkg::EPS_MODE_LOADVER);

    // Shadow keypad register and pulse length counter
    always_ff @(posedge clk_sys_i or posedge rst_i) begin
        if (rst_i) begin
            key_reg  <= 8'h00;
            plen_reg <= 32'h0;
        end else begin
            if (digit_stb_i) key_reg <= {key_reg[3:0], digit_i};
            plen_reg <= dev_prog_pulse_o ? plen_reg + 32'h1 : 32'h0;
        end
    end

    default clocking cb @(posedge clk_sys_i); endclocking
    default disable iff (rst_i);

    // ****
    // Properties
    // ****
    property p_upper;
        upper_set_i && kp_idle |-> ##2 addr_disp_o[12:8] == $past(ktop, 2);
    endproperty
    a_upper: assert property (p_upper) else $error("upper pair wrong");
    property p_lower;
        lower_set_i && kp_idle |-> ##2 addr_disp_o[7:0] == $past(key_reg, 2);
    endproperty
    a_lower: assert property (p_lower) else $error("lower pair wrong");
    property p_adv;
        scan_run_o && $past(scan_run_o) && $changed(addr_disp_o) |->
            addr_disp_o[11:0] == $past(addr_disp_o[11:0]) + 12'h001;
    endproperty
    a_adv: assert property (p_adv) else $error("bad advance");
    property p_top;
        scan_run_o && $past(scan_run_o) |-> $stable(addr_disp_o[12]);
    endproperty
    a_top: assert property (p_top) else $error("top digit moved");
    property p_start;
        write_step_i && !scan_run_o && !stop_i && scan_mode |=> scan_run_o;
    endproperty
    a_start: assert property (p_start) else $error("scan not started");
    property p_stop;
        scan_run_o && stop_i |=> !scan_run_o;
    endproperty
    a_stop: assert property (p_stop) else $error("scan not stopped");
    property p_mism;
        $rose(mismatch_o) |-> !scan_run_o && $past(scan_run_o) &&
            $past(mode_i) == eps_pkg::EPS_MODE_LOADVER;
    endproperty
    a_mism: assert property (p_mism) else $error("bad mismatch stop");
    property p_emu;
        mode_i == eps_pkg::EPS_MODE_EMULATE |=>
            dev_data_oe_o == !$past(ext_sel_n_i);
    endproperty
    a_emu: assert property (p_emu) else $error("emulate drive wrong");
    property p_pulse;
        $fell(dev_prog_pulse_o) && !$past(stop_i) &&
            $past(mode_i) == eps_pkg::EPS_MODE_BURN |->
            plen_reg == ($past(psel_i) == eps_pkg::EPS_PSEL_LONG ?
                         PULSE_LONG_CYC : PULSE_SHORT_CYC);
    endproperty
    a_pulse: assert property (p_pulse) else $error("pulse width");

    // Main scenarios reached
    c_burn: cover property ($fell(dev_prog_pulse_o));
    c_mism: cover property ($rose(mismatch_o));
    c_stop: cover property (scan_run_o && stop_i);
endmodule

bind eps_scan_ctrl eps_scan_ctrl_chk #(
    .PULSE_SHORT_CYC(PULSE_SHORT_CYC), .PULSE_LONG_CYC(PULSE_LONG_CYC)
) u_chk (
    .clk_sys_i, .rst_i, .mode_i, .psel_i, .stop_i, .digit_stb_i, .digit_i,
    .upper_set_i, .lower_set_i, .write_step_i, .ext_sel_n_i,
    .dev_prog_pulse_o, .dev_data_oe_o, .addr_disp_o, .scan_run_o, .mismatch_o
);
`default_nettype wire

// [verification/eps_dev_model.sv]
// Behavioural device in the socket
`timescale 1ns/1ps
`default_nettype none

module eps_dev_model (
    input wire logic        clk_sys_i, // Clock
    input wire logic [12:0] addr_i,    // Socket address
    input wire logic        sel_n_i,   // Socket select
    input wire logic [7:0]  data_i,    // Data to burn
    input wire logic        oe_i,      // Data driven
    input wire logic        prog_i,    // Program pulse
    output logic [7:0]      data_o     // Data read
);
    logic [7:0] mem [0:8191], last;

    // Level-sensitive read; released bus shows inverted last word
    assign data_o = !sel_n_i ? mem[addr_i] : ~last;

    // Burning only clears bits
    always @(posedge clk_sys_i) begin
        if (!sel_n_i) last <= mem[addr_i];
        if (prog_i && oe_i) mem[addr_i] <= mem[addr_i] & data_i;
    end
endmodule
`default_nettype wire

// [verification/eps_scan_ctrl_bench.sv]
// Self-checking bench of the scan control block
`timescale 1ns/1ps
`default_nettype none

module eps_scan_ctrl_bench;
    logic clk_sys_i = 1'b0, rst_i = 1'b1, stop_i = 1'b0;
    eps_pkg::eps_mode_type mode_i = eps_pkg::EPS_MODE_KEYPAD;
    eps_pkg::eps_psel_type psel_i = eps_pkg::EPS_PSEL_SHORT;
    logic write_permit_i = 1'b0, repeat_i = 1'b0, digit_stb_i = 1'b0;
    logic show_device_word_button_i = 1'b0, write_step_i = 1'b0;
    logic upper_set_i = 1'b0, lower_set_i = 1'b0, ext_sel_n_i = 1'b1;
    logic ser_valid_i = 1'b0, ser_write_i = 1'b0;
    logic [3:0]  digit_i = 4'h0;
    logic [7:0]  ser_data_i = 8'h00, dev_data_i;
    logic [12:0] ext_addr_i = 13'h0000, ser_addr_i = 13'h0000;
    logic        ser_ready_o, ser_rd_valid_o, dev_sel_n_o, dev_data_oe_o;
    logic        dev_prog_pulse_o, scan_run_o, mismatch_o;
    logic [7:0]  ser_rd_data_o, dev_data_o, data_disp_o;
    logic [12:0] dev_addr_o, addr_disp_o;
    int          num_errors = 0, compares = 0, cycles = 0;

    eps_scan_ctrl #(.PULSE_SHORT_CYC(20), .PULSE_LONG_CYC(40)) u_dut (
        .clk_sys_i, .rst_i, .mode_i, .psel_i, .write_permit_i, .repeat_i,
        .stop_i, .show_device_word_button_i, .digit_stb_i, .digit_i,
        .upper_set_i, .lower_set_i, .write_step_i, .dev_data_i, .ext_addr_i,
        .ext_sel_n_i, .ser_valid_i, .ser_write_i, .ser_addr_i, .ser_data_i,
        .ser_ready_o, .ser_rd_valid_o, .ser_rd_data_o, .dev_addr_o,
        .dev_sel_n_o, .dev_data_o, .dev_data_oe_o, .dev_prog_pulse_o,
        .addr_disp_o, .data_disp_o, .scan_run_o, .mismatch_o);
    eps_dev_model u_dev (.clk_sys_i(clk_sys_i), .addr_i(dev_addr_o),
        .sel_n_i(dev_sel_n_o), .data_i(dev_data_o), .oe_i(dev_data_oe_o),
        .prog_i(dev_prog_pulse_o), .data_o(dev_data_i));

    // ****
    // Clock, timeout and helpers
    // ****
    initial forever #5 clk_sys_i = ~clk_sys_i;

    // Hang guard
    always @(posedge clk_sys_i) begin
        cycles++;
        if (cycles == 20000) begin
            num_errors++;
            tally_and_finish();
        end
    end

    task automatic tk(input int n);
        repeat (n) @(posedge clk_sys_i);
        #1;
    endtask
    task automatic chk(input string what, input logic [12:0] e, got);
        compares++;
        if (got !== e) begin
            num_errors++;
            $display("CHECK FAILED %s expected %h seen %h", what, e, got);
        end
    endtask
    task automatic key(input logic [3:0] d);
        digit_i = d;
        digit_stb_i = 1'b1;
        tk(1);
        digit_stb_i = 1'b0;
        tk(1);
    endtask
    task automatic pair(input logic [7:0] v);
        key(v[7:4]);
        key(v[3:0]);
    endtask
    task automatic hit(input int k);
        {upper_set_i, lower_set_i, write_step_i} = 3'b100 >> k;
        tk(1);
        {upper_set_i, lower_set_i, write_step_i} = 3'b000;
        tk(3);
    endtask
    task automatic goto(input logic [12:0] a);
        pair({3'h0, a[12:8]});
        hit(0);
        pair(a[7:0]);
        hit(1);
        tk(2);
    endtask
    task automatic look(input logic [12:0] a, input logic [7:0] v);
        goto(a);
        chk("ram word", {5'h00, v}, {5'h00, data_disp_o});
    endtask
    task automatic run(input int n);
        hit(2);
        tk(n);
        stop_i = 1'b1;
        tk(1);
        stop_i = 1'b0;
        tk(2);
    endtask

    // ****
    // Scenarios
    // ****
    task automatic t_keypad();
        write_permit_i = 1'b1;
        goto(13'h0FFE);
        pair(8'hA5);
        hit(2);
        pair(8'h5A);
        hit(2);
        pair(8'h3C);
        hit(2);
        chk("wrap address", 13'h0001, addr_disp_o);
        look(13'h0FFE, 8'hA5);
        write_permit_i = 1'b0;
        hit(2);
        chk("step address", 13'h0FFF, addr_disp_o);
        look(13'h0FFE, 8'hA5);
        $display("t_keypad done");
    endtask
    task automatic t_burn();
        for (int p = 0; p < 2; p++) begin
            goto(13'h0FFE);
            mode_i = eps_pkg::EPS_MODE_BURN;
            psel_i = eps_pkg::eps_psel_type'(p);
            run(60 + 40 * p);
            chk("stopped", 13'h0000, {12'h000, scan_run_o});
            chk("top digit", 13'h0000, {12'h000, addr_disp_o[12]});
            mode_i = eps_pkg::EPS_MODE_KEYPAD;
        end
        chk("burn 0FFE", 13'h00A5, {5'h00, u_dev.mem[13'h0FFE]});
        chk("burn 0FFF", 13'h005A, {5'h00, u_dev.mem[13'h0FFF]});
        $display("t_burn done");
    endtask
    task automatic t_verify();
        u_dev.mem[13'h0FFF] = 8'h00;
        u_dev.mem[13'h0000] = 8'h3C;
        goto(13'h0FFE);
        mode_i = eps_pkg::EPS_MODE_LOADVER;
        hit(2);
        tk(20);
        chk("mismatch", 13'h0001, {12'h000, mismatch_o});
        chk("fail address", 13'h0FFF, addr_disp_o);
        show_device_word_button_i = 1'b1;
        tk(4);
        chk("device word", 13'h0000, {5'h00, data_disp_o});
        show_device_word_button_i = 1'b0;
        mode_i = eps_pkg::EPS_MODE_KEYPAD;
        hit(2);
        chk("passed", 13'h0000, addr_disp_o);
        mode_i = eps_pkg::EPS_MODE_LOADVER;
        hit(2);
        chk("resumed", 13'h0001, {12'h000, scan_run_o});
        chk("cleared", 13'h0000, {12'h000, mismatch_o});
        run(1);
        mode_i = eps_pkg::EPS_MODE_KEYPAD;
        $display("t_verify done");
    endtask
    task automatic t_load_repeat();
        u_dev.mem[13'h1000] = 8'h11;
        u_dev.mem[13'h1001] = 8'h22;
        write_permit_i = 1'b1;
        goto(13'h1000);
        mode_i = eps_pkg::EPS_MODE_LOADVER;
        run(10);
        mode_i = eps_pkg::EPS_MODE_KEYPAD;
        look(13'h1000, 8'h11);
        look(13'h1001, 8'h22);
        goto(13'h1100);
        pair(8'h77);
        repeat_i = 1'b1;
        hit(2);
        tk(245);
        repeat_i = 1'b0;
        tk(2);
        chk("fill address", 13'h1103, addr_disp_o);
        look(13'h1102, 8'h77);
        $display("t_load_repeat done");
    endtask
    task automatic t_emulate();
        mode_i = eps_pkg::EPS_MODE_EMULATE;
        ext_addr_i = 13'h0FFE;
        ext_sel_n_i = 1'b0;
        tk(3);
        chk("emu word", 13'h00A5, {5'h00, dev_data_o});
        ext_addr_i = 13'h1000;
        tk(3);
        chk("emu upper", 13'h0011, {5'h00, dev_data_o});
        ext_sel_n_i = 1'b1;
        tk(2);
        chk("emu release", 13'h0000, {12'h000, dev_data_oe_o});
        mode_i = eps_pkg::EPS_MODE_KEYPAD;
        $display("t_emulate done");
    endtask
    task automatic t_serial();
        int  n = 0;
        mode_i = eps_pkg::EPS_MODE_BURN;
        psel_i = eps_pkg::EPS_PSEL_SERIAL;
        {ser_valid_i, ser_write_i} = 2'b11;
        repeat (40) begin
            ser_addr_i = 13'h0100 + 13'(n);
            ser_data_i = 8'(n);
            if (ser_ready_o === 1'b1) n++;
            tk(1);
        end
        chk("fifo taken", 13'd32, 13'(n));
        {ser_valid_i, ser_write_i} = 2'b00;
        mode_i = eps_pkg::EPS_MODE_KEYPAD;
        tk(40);
        ser_addr_i = 13'h0105;
        ser_valid_i = 1'b1;
        tk(1);
        ser_valid_i = 1'b0;
        for (int k = 0; k < 10 && ser_rd_valid_o !== 1'b1; k++) tk(1);
        chk("read valid", 13'h0001, {12'h000, ser_rd_valid_o});
        chk("read answer", 13'h0005, {5'h00, ser_rd_data_o});
        look(13'h011F, 8'h1F);
        $display("t_serial done");
    endtask

    task automatic tally_and_finish();
        $display("compares %0d num_errors %0d", compares, num_errors);
        if (num_errors == 0 && compares > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask

    // Main sequence
    initial begin
        for (int i = 0; i < 8192; i++) u_dev.mem[i] = 8'hFF;
        tk(16);
        rst_i = 1'b0;
        tk(2);
        t_keypad();
        t_burn();
        t_verify();
        t_load_repeat();
        t_emulate();
        t_serial();
        tally_and_finish();
    end
endmodule
`default_nettype wire
